// ==== verilog/cfb_pkg.sv ====
// Package with register map, field layout and carrier types for the filter buffer pointers.
// Overview of operation
// - Filters 4-7 register, filter 7 top nibble.
// - Filter 6 destination in bits 11:8.
// - Filter 5 destination in bits 7:4.
// - Filter 4 destination in bits 3:0.
// - Filters 8-11 register, 11 top, 8 lowest.
// - Values 0-14 select that receive buffer.
package cfb_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int FIELD_W = 4;
  localparam logic [ADDR_W-1:0] PTR_4_7_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] PTR_8_11_OFFSET = 4'h2;
  localparam logic [DATA_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 16'h0000;
  localparam logic [FIELD_W-1:0] DEST_FIFO_CODE = 4'hf;
  localparam int FIRST_FILTER = 4;
  localparam int FILTER_COUNT = 8;
  localparam int FILTER_SEL_W = 4;

  typedef struct packed {
    logic valid;
    logic [FILTER_SEL_W-1:0] filter;
  } cfb_hit_t;

  typedef struct packed {
    logic valid;
    logic to_fifo;
    logic [FIELD_W-1:0] buffer;
  } cfb_dest_t;
endpackage : cfb_pkg

// ==== verilog/cfb_filter_buffer_pointers.sv ====
// Destination pointer registers for acceptance filters 4 to 11 and the hit-to-buffer lookup.
//
// The implementer's own choices: the address map and strobed register access.
module cfb_filter_buffer_pointers (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [cfb_pkg::ADDR_W-1:0] addr_i,
  input wire logic [cfb_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [cfb_pkg::DATA_W-1:0] rdata_o,
  input wire cfb_pkg::cfb_hit_t hit_i,
  output cfb_pkg::cfb_dest_t dest_o
);
  import cfb_pkg::*;

  // Two sixteen-bit words hold eight four-bit destination fields, four per word.
  // Software writes a whole word at a time; there is no per-field write mask, so a
  // driver that wants to change one filter must read, merge and write back.
  // The lookup side turns a filter hit into a destination for the message store:
  // a field value below fifteen names a receive buffer, fifteen names the FIFO area.
  // The answer is registered, one cycle after the hit, so the store sees a clean
  // value even when software rewrites the field in the same cycle as the hit.
  // A hit in the cycle of a write still sees the old field; the new value applies
  // to hits from the next cycle on.
  // Hits outside the covered range give a zero destination with valid low.
  // The register port never stalls: writes land at the next edge, reads answer one later.

  // Filters held in each word.
  localparam int HALF = FILTER_COUNT / 2;

  // Pointer word storage.
  logic [DATA_W-1:0] ptr_4_7_reg;
  logic [DATA_W-1:0] ptr_4_7_next;
  logic [DATA_W-1:0] ptr_8_11_reg;
  logic [DATA_W-1:0] ptr_8_11_next;

  // Address decode of the register port.
  logic sel_4_7;
  logic sel_8_11;
  logic wr_4_7;
  logic wr_8_11;
  logic rd_4_7;
  logic rd_8_11;

  // Read data path.
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // Hit lookup path.
  logic [FIELD_W-1:0] field [FILTER_COUNT];
  logic [FILTER_COUNT-1:0] hit_onehot;
  logic hit_low_ok;
  logic hit_high_ok;
  logic hit_take;
  logic [FILTER_SEL_W-1:0] hit_offset;
  logic [FIELD_W-1:0] hit_field;
  cfb_dest_t dest_reg;
  cfb_dest_t dest_next;

  // An address that matches neither word selects nothing, so writes there are dropped
  // and reads there return zero.
  always_comb
  begin
    sel_4_7 = (addr_i == PTR_4_7_OFFSET);
    sel_8_11 = (addr_i == PTR_8_11_OFFSET);
    wr_4_7 = wr_i && sel_4_7;
    wr_8_11 = wr_i && sel_8_11;
    rd_4_7 = rd_i && sel_4_7;
    rd_8_11 = rd_i && sel_8_11;
  end

  // Only hits for filters 4 to 11 are answered; lower and higher filters belong to
  // other logic and must not disturb the destination seen by the message store.
  always_comb
  begin
    hit_low_ok = (hit_i.filter >= FILTER_SEL_W'(FIRST_FILTER));
    hit_high_ok = (hit_i.filter < FILTER_SEL_W'(FIRST_FILTER + FILTER_COUNT));
    hit_take = hit_i.valid && hit_low_ok && hit_high_ok;
    hit_offset = hit_i.filter - FILTER_SEL_W'(FIRST_FILTER);
  end

  // Nibble n of each word belongs to the n-th filter of that word, counted upward.
  // Filter 7 and filter 11 therefore sit in the top nibble of their word.
  // Each filter also gets its own select line, so the field mux stays a flat OR.
  genvar g;
  generate
    for (g = 0; g < HALF; g++)
    begin : g_field
      assign field[g] = ptr_4_7_reg[g*FIELD_W +: FIELD_W];
      assign field[g + HALF] = ptr_8_11_reg[g*FIELD_W +: FIELD_W];
      assign hit_onehot[g] = hit_take && (hit_offset == FILTER_SEL_W'(g));
      assign hit_onehot[g + HALF] = hit_take && (hit_offset == FILTER_SEL_W'(g + HALF));
    end
  endgenerate

  // All sixteen bits of each word are writable; a write takes effect at the next edge.
  // Both strobes are never high together, so the write path ignores the read strobe.
  always_comb
  begin
    ptr_4_7_next = ptr_4_7_reg;
    ptr_8_11_next = ptr_8_11_reg;
    if (wr_4_7)
    begin
      ptr_4_7_next = wdata_i;
    end
    if (wr_8_11)
    begin
      ptr_8_11_next = wdata_i;
    end
  end

  // Every field clears to zero, which sends all eight filters to receive buffer 0
  // until software sets them up.
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      ptr_4_7_reg <= PTR_RESET;
    end
    else
    begin
      ptr_4_7_reg <= ptr_4_7_next;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      ptr_8_11_reg <= PTR_RESET;
    end
    else
    begin
      ptr_8_11_reg <= ptr_8_11_next;
    end
  end

  // Read data stand for one cycle and fall back to zero, so the port can be OR-ed
  // with other slaves on a shared read bus.
  // Both selects high at once cannot happen and falls to the default.
  always_comb
  begin
    case ({rd_8_11, rd_4_7})
      2'b01:
      begin
        rdata_next = ptr_4_7_reg;
      end
      2'b10:
      begin
        rdata_next = ptr_8_11_reg;
      end
      default:
      begin
        rdata_next = READ_UNMAPPED;
      end
    endcase
  end

  // Reset also drops a read in flight, so a read issued during reset returns zero.
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      rdata_reg <= READ_UNMAPPED;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // At most one select line is high, so OR-ing the masked fields picks one field.
  always_comb
  begin
    hit_field = '0;
    for (int i = 0; i < FILTER_COUNT; i++)
    begin
      if (hit_onehot[i])
      begin
        hit_field = hit_field | field[i];
      end
    end
  end

  // The buffer field keeps the raw code even for the FIFO case, so the store can
  // tell the two apart by the flag alone and still log the code it was given.
  always_comb
  begin
    dest_next = '0;
    if (hit_take)
    begin
      dest_next.valid = 1'b1;
      case (hit_field)
        DEST_FIFO_CODE:
        begin
          dest_next.to_fifo = 1'b1;
          dest_next.buffer = hit_field;
        end
        default:
        begin
          dest_next.to_fifo = 1'b0;
          dest_next.buffer = hit_field;
        end
      endcase
    end
  end

  // A hit that arrives while reset holds is lost; the filter logic must wait for release.
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      dest_reg <= '0;
    end
    else
    begin
      dest_reg <= dest_next;
    end
  end

  // Outputs come straight from the registers, so the store never sees decode glitches.
  assign rdata_o = rdata_reg;
  assign dest_o = dest_reg;
endmodule : cfb_filter_buffer_pointers

// ==== test/cfb_monitor.sv ====
// Checker on the register port and the hit lookup ports.
module cfb_monitor (
  input logic ref_clk_i,
  input logic nrst_i,
  input logic [cfb_pkg::ADDR_W-1:0] addr_i,
  input logic [cfb_pkg::DATA_W-1:0] wdata_i,
  input logic wr_i,
  input logic rd_i,
  input logic [cfb_pkg::DATA_W-1:0] rdata_o,
  input cfb_pkg::cfb_hit_t hit_i,
  input cfb_pkg::cfb_dest_t dest_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_DEST: assert property (hit_i.valid && hit_i.filter inside {[4:11]} |=>
    dest_o.valid && dest_o.to_fifo == &dest_o.buffer) else $error("Bad destination");
  AST_IDLE: assert property (!hit_i.valid |=> !dest_o.valid) else $error("Stray hit");
  AST_OUT_RANGE: assert property (hit_i.valid && !(hit_i.filter inside {[4:11]}) |=>
    !dest_o.valid) else $error("Hit outside range answered");
  AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("Read data without read");
  AST_RW_4_7: assert property (wr_i && addr_i == 4'h0 ##1 rd_i && addr_i == 4'h0 |=>
    rdata_o == $past(wdata_i, 2)) else $error("Filters 4-7 word read back wrong");
  AST_RW_8_11: assert property (wr_i && addr_i == 4'h2 ##1 rd_i && addr_i == 4'h2 |=>
    rdata_o == $past(wdata_i, 2)) else $error("Filters 8-11 word read back wrong");
endmodule : cfb_monitor

// ==== test/cfb_filter_buffer_pointers_bench.sv ====
// Directed bench for the destination registers.
module cfb_filter_buffer_pointers_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0;
  logic [3:0] addr_i = 0;
  logic [15:0] wdata_i = 0, rdata_o;
  logic [4:0] hit_i = 0;
  logic [5:0] dest_o;
  int num_errors = 0, comparisons = 0, cycles = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  cfb_filter_buffer_pointers dut (.*);
  // The run needs under 50 cycles; 200 leaves room without hiding a hang.
  always @(posedge ref_clk_i) if (cycles++ == 200) final_report(1);
  // Each call checks what the previous call's inputs produced.
  task automatic cy(logic w, r, logic [3:0] a, logic [15:0] d, logic [4:0] h, logic [21:0] e);
    @(posedge ref_clk_i);
    {wr_i, rd_i, addr_i, wdata_i, hit_i} <= {w, r, a, d, h};
    #1 comparisons++;
    num_errors += ({rdata_o, dest_o} !== e);
    if ({rdata_o, dest_o} !== e)
      $display("Error out expected %h seen %h", e, {rdata_o, dest_o});
  endtask : cy
  task automatic final_report(bit hung);
    num_errors += hung;
    $display("errors %0d checks %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic t_map;
    cy(1, 0, 4'h2, 16'hBA98, 5'h00, 22'h0);
    cy(1, 0, 4'h0, 16'hF321, 5'h1B, 22'h0);
    cy(0, 1, 4'h0, 16'h0, 5'h17, 22'h2B);
    cy(0, 1, 4'h2, 16'h0, 5'h14, {16'hF321, 6'h3F});
    cy(0, 1, 4'h1, 16'h0, 5'h16, {16'hBA98, 6'h21});
    cy(0, 0, 4'h0, 16'h0, 5'h15, 22'h23);
    cy(0, 0, 4'h0, 16'h0, 5'h13, 22'h22);
    cy(0, 0, 4'h0, 16'h0, 5'h00, 22'h0);
  endtask : t_map
  task automatic t_reset_values;
    cy(0, 1, 4'h0, 16'h0000, 5'h00, 22'h0);
    cy(0, 1, 4'h2, 16'h0000, 5'h18, 22'h0);
    cy(0, 0, 4'h0, 16'h0000, 5'h00, {16'h0000, 6'h20});
  endtask : t_reset_values
  task automatic t_upper;
    cy(0, 0, 4'h0, 16'h0000, 5'h18, 22'h0);
    cy(0, 0, 4'h0, 16'h0000, 5'h19, 22'h28);
    cy(0, 0, 4'h0, 16'h0000, 5'h1A, 22'h29);
    cy(1, 0, 4'h2, 16'h0E5F, 5'h00, 22'h2A);
    cy(0, 1, 4'h2, 16'h0000, 5'h18, 22'h0);
    cy(1, 0, 4'h3, 16'hFFFF, 5'h1B, {16'h0E5F, 6'h3F});
    cy(0, 1, 4'h0, 16'h0000, 5'h1A, {16'h0000, 6'h20});
    cy(0, 0, 4'h0, 16'h0000, 5'h00, {16'hF321, 6'h2E});
  endtask : t_upper
  task automatic t_mid_reset;
    cy(0, 0, 4'h0, 16'h0000, 5'h14, 22'h0);
    cy(0, 0, 4'h0, 16'h0000, 5'h00, 22'h21);
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    cy(0, 1, 4'h0, 16'h0000, 5'h14, 22'h0);
    cy(0, 1, 4'h2, 16'h0000, 5'h00, {16'h0000, 6'h20});
    cy(0, 0, 4'h0, 16'h0000, 5'h00, 22'h0);
  endtask : t_mid_reset
  initial
  begin
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    t_reset_values();
    t_map();
    t_upper();
    t_mid_reset();
    final_report(1'b0);
  end
endmodule : cfb_filter_buffer_pointers_bench
bind cfb_filter_buffer_pointers cfb_monitor mon (.*);
